// >>> rtl/pmr_register_bank.sv
/*
  Register bank of a multi-rail power controller, reached over a two-wire
  serial link as a slave, with latched fault events and an interrupt pin.
  Assumes SCL and SDA arrive asynchronously and are well below a quarter of
  the 100 MHz clock; the pad logic resolves SDA from sda_oe_n.
*/
// How it works
// - A high SDA rising while SCL stays high ends the transaction.
// - Repeated start restarts address reception but keeps the register pointer.
// - Burst reads continue to the next register after each acknowledged byte.
// - Offsets zero and one are read-only product and silicon revision codes.
// - Buck target code is the full eight-bit field.
// - Bit seven of each LDO register is that LDO's bypass control.
// - Current limit selects sit at bits six, four, two, zero; odd bits zero.
// - Enable register: boost mode, buck mode, buck enable, four LDO enables.
// - Boost enable register holds eight independent boost enable bits.
// - Sequencer register holds pace, trigger, active flag and step count.
// - Discharge register holds load bits and per-rail discharge bits.
// - Reset register holds the soft reset field and retry policy bit zero.
// - Event registers latch fault rises; state registers show live conditions.
// - Each mask bit stops its matching event from reaching the interrupt pin.
// - Suspend register shows chip, boost, buck and LDO flags; bit seven zero.
// - SDA falling while SCL stays high starts a transaction.
// - The slave answers address 0110101; eighth bit one means read.
// - Interrupt pin goes low on an unmasked event, high once all are cleared.
// - Retry policy resets to zero, the four-restart limit.
`timescale 1ns/1ns
`default_nettype none

module pmr_register_bank
  import pmr_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDRESS = SLAVE_ADDRESS,
  // Arbitrary value.
  parameter logic [7:0] PRODUCT_CODE = 8'h5a,
  // Arbitrary value.
  parameter logic [7:0] REVISION_CODE = 8'ha5
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic irq_n_pin,
  input wire logic [7:0] ldo_limit_cond,
  input wire logic [7:0] converter_limit_cond,
  input wire logic [7:0] supply_thermal_cond,
  input wire logic [6:0] suspend_cond,
  output logic [7:0] buck_voltage,
  output logic [7:0] boost_voltage,
  output logic [7:0] ldo_one_voltage,
  output logic [7:0] ldo_two_voltage,
  output logic [7:0] ldo_three_voltage,
  output logic [7:0] ldo_four_voltage,
  output logic [7:0] current_limit_select,
  output logic [7:0] rail_enable,
  output logic [7:0] boost_enable_set,
  output logic [7:0] buck_sequence_slot,
  output logic [7:0] ldo_one_two_sequence_slot,
  output logic [7:0] ldo_three_four_sequence_slot,
  output logic [7:0] sequencer_control,
  output logic [7:0] discharge_and_load,
  output logic [7:0] reset_and_fault_policy
);

  // ----------------------------------------
  // Types and functions
  // ----------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE      = 9'b0_0000_0001,
    ST_ADDR      = 9'b0_0000_0010,
    ST_ADDR_ACK  = 9'b0_0000_0100,
    ST_PTR       = 9'b0_0000_1000,
    ST_PTR_ACK   = 9'b0_0001_0000,
    ST_WDATA     = 9'b0_0010_0000,
    ST_WDATA_ACK = 9'b0_0100_0000,
    ST_RDATA     = 9'b0_1000_0000,
    ST_RDATA_ACK = 9'b1_0000_0000
  } pmr_state_e;

  // Writable bits per offset; read-only and absent offsets get none.
  function automatic logic [7:0] write_mask(input logic [7:0] a);
    case (a)
      REG_BUCK_VOLTAGE: write_mask = WMASK_FULL;
      REG_BOOST_VOLTAGE: write_mask = WMASK_FULL;
      REG_LDO_ONE_VOLTAGE, REG_LDO_TWO_VOLTAGE,
      REG_LDO_THREE_VOLTAGE, REG_LDO_FOUR_VOLTAGE: write_mask = WMASK_FULL;
      REG_CURRENT_LIMIT: write_mask = WMASK_CURRENT_LIMIT;
      REG_RAIL_ENABLE: write_mask = WMASK_RAIL_ENABLE;
      REG_BOOST_ENABLE_SET: write_mask = WMASK_FULL;
      REG_BUCK_SLOT: write_mask = WMASK_BUCK_SLOT;
      REG_LDO_ONE_TWO_SLOT, REG_LDO_THREE_FOUR_SLOT: write_mask = WMASK_PAIR_SLOT;
      REG_SEQUENCER_CONTROL: write_mask = WMASK_FULL;
      REG_DISCHARGE_AND_LOAD: write_mask = WMASK_FULL;
      REG_RESET_AND_POLICY: write_mask = WMASK_RESET_AND_POLICY;
      REG_LDO_LIMIT_MASK, REG_CONVERTER_MASK, REG_SUPPLY_MASK: write_mask = WMASK_FULL;
      default: write_mask = WMASK_NONE;
    endcase
  endfunction

  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  logic scl_s1, scl_s2, scl_q;
  logic sda_s1, sda_s2, sda_q;
  logic scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_q <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_q <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_q <= sda_s2;
    end
  end

  assign scl_rise = scl_s2 & ~scl_q;
  assign scl_fall = ~scl_s2 & scl_q;
  assign start_det = scl_s2 & scl_q & sda_q & ~sda_s2;
  assign stop_det = scl_s2 & scl_q & ~sda_q & sda_s2;

  // Fault condition synchronisers; the third stage only feeds edge detection.
  logic [7:0] cond_s1 [EVENT_REGS];
  logic [7:0] cond_s2 [EVENT_REGS];
  logic [7:0] cond_q [EVENT_REGS];
  logic [6:0] susp_s1, susp_s2;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < EVENT_REGS; i++) begin
        cond_s1[i] <= 8'h00;
        cond_s2[i] <= 8'h00;
        cond_q[i] <= 8'h00;
      end
      susp_s1 <= 7'h00;
      susp_s2 <= 7'h00;
    end else begin
      cond_s1[0] <= ldo_limit_cond;
      cond_s1[1] <= converter_limit_cond;
      cond_s1[2] <= supply_thermal_cond;
      for (int i = 0; i < EVENT_REGS; i++) begin
        cond_s2[i] <= cond_s1[i];
        cond_q[i] <= cond_s2[i];
      end
      susp_s1 <= suspend_cond;
      susp_s2 <= susp_s1;
    end
  end

  // ----------------------------------------
  // Link state machine
  // ----------------------------------------
  pmr_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [7:0] pointer;
  logic read_dir;
  logic host_acked;
  logic [7:0] next_pointer;
  logic load_now;
  logic [7:0] load_addr;
  logic [7:0] load_byte;
  logic byte_done;
  logic write_now;
  logic [7:0] regs [REG_COUNT];
  logic [7:0] event_flag [EVENT_REGS];
  logic [7:0] event_mask [EVENT_REGS];

  // Saturating so that a long burst parks beyond the map instead of wrapping.
  assign next_pointer = (pointer == REG_POINTER_MAX) ? pointer : pointer + 8'h01;
  assign byte_done = scl_fall && (bit_cnt == BITS_PER_BYTE);
  assign write_now = (state == ST_WDATA) && byte_done;
  assign load_now = scl_fall && (((state == ST_ADDR_ACK) && read_dir) ||
                                 ((state == ST_RDATA_ACK) && host_acked));
  assign load_addr = (state == ST_ADDR_ACK) ? pointer : next_pointer;

  for (genvar g = 0; g < EVENT_REGS; g++) begin : g_mask
    assign event_mask[g] = regs[int'(REG_LDO_LIMIT_MASK) + g];
  end

  always_comb begin
    case (load_addr)
      REG_PRODUCT_CODE: load_byte = PRODUCT_CODE;
      REG_SILICON_REVISION: load_byte = REVISION_CODE;
      REG_LDO_LIMIT_EVENTS: load_byte = event_flag[0];
      REG_CONVERTER_EVENTS: load_byte = event_flag[1];
      REG_SUPPLY_EVENTS: load_byte = event_flag[2];
      REG_LDO_LIMIT_STATE: load_byte = cond_s2[0];
      REG_CONVERTER_STATE: load_byte = cond_s2[1];
      REG_SUPPLY_STATE: load_byte = cond_s2[2];
      REG_SUSPEND_STATE: load_byte = {1'b0, susp_s2};
      REG_RESET_AND_POLICY: load_byte = regs[REG_RESET_AND_POLICY[4:0]] | READ_ONE_RESET_AND_POLICY;
      default: begin
        if (load_addr > REG_LAST) begin
          load_byte = FILL_BYTE;
        end else begin
          load_byte = regs[load_addr[4:0]] & write_mask(load_addr);
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      pointer <= 8'h00;
      read_dir <= 1'b0;
      host_acked <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (start_det) begin
      // Pointer is kept across a repeated start so a read follows the address write.
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe_n <= 1'b1;
    end else if (stop_det) begin
      state <= ST_IDLE;
      sda_oe_n <= 1'b1;
    end else begin
      if (scl_rise && (state == ST_ADDR || state == ST_PTR || state == ST_WDATA)) begin
        shift_in <= {shift_in[6:0], sda_s2};
        bit_cnt <= bit_cnt + 4'h1;
      end
      case (state)
        ST_IDLE: begin
          sda_oe_n <= 1'b1;
        end
        ST_ADDR: begin
          if (byte_done) begin
            bit_cnt <= 4'h0;
            if (shift_in[7:1] == DEVICE_ADDRESS) begin
              read_dir <= shift_in[0];
              sda_oe_n <= 1'b0;
              state <= ST_ADDR_ACK;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (read_dir) begin
              shift_out <= load_byte;
              sda_oe_n <= load_byte[7];
              state <= ST_RDATA;
            end else begin
              sda_oe_n <= 1'b1;
              state <= ST_PTR;
            end
          end
        end
        ST_PTR: begin
          if (byte_done) begin
            pointer <= shift_in;
            bit_cnt <= 4'h0;
            sda_oe_n <= 1'b0;
            state <= ST_PTR_ACK;
          end
        end
        ST_PTR_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            sda_oe_n <= 1'b1;
            state <= ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (byte_done) begin
            // Read-only targets still get acknowledged so the host sees no error.
            pointer <= next_pointer;
            bit_cnt <= 4'h0;
            sda_oe_n <= 1'b0;
            state <= ST_WDATA_ACK;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt == LAST_BIT) begin
              bit_cnt <= 4'h0;
              sda_oe_n <= 1'b1;
              state <= ST_RDATA_ACK;
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
              shift_out <= {shift_out[6:0], 1'b0};
              sda_oe_n <= shift_out[6];
            end
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            host_acked <= ~sda_s2;
          end
          if (scl_fall) begin
            if (host_acked) begin
              pointer <= next_pointer;
              shift_out <= load_byte;
              sda_oe_n <= load_byte[7];
              state <= ST_RDATA;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          sda_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // Open drain: only the enable toggles.
  always_ff @(posedge clock) begin
    sda_out <= 1'b0;
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= RESET_OTHER;
      end
      regs[REG_CURRENT_LIMIT[4:0]] <= RESET_CURRENT_LIMIT;
    end else if (write_now && (pointer <= REG_LAST)) begin
      regs[pointer[4:0]] <= shift_in & write_mask(pointer);
    end
  end

  assign buck_voltage = regs[REG_BUCK_VOLTAGE[4:0]];
  assign boost_voltage = regs[REG_BOOST_VOLTAGE[4:0]];
  assign ldo_one_voltage = regs[REG_LDO_ONE_VOLTAGE[4:0]];
  assign ldo_two_voltage = regs[REG_LDO_TWO_VOLTAGE[4:0]];
  assign ldo_three_voltage = regs[REG_LDO_THREE_VOLTAGE[4:0]];
  assign ldo_four_voltage = regs[REG_LDO_FOUR_VOLTAGE[4:0]];
  assign current_limit_select = regs[REG_CURRENT_LIMIT[4:0]];
  assign rail_enable = regs[REG_RAIL_ENABLE[4:0]];
  assign boost_enable_set = regs[REG_BOOST_ENABLE_SET[4:0]];
  assign buck_sequence_slot = regs[REG_BUCK_SLOT[4:0]];
  assign ldo_one_two_sequence_slot = regs[REG_LDO_ONE_TWO_SLOT[4:0]];
  assign ldo_three_four_sequence_slot = regs[REG_LDO_THREE_FOUR_SLOT[4:0]];
  assign sequencer_control = regs[REG_SEQUENCER_CONTROL[4:0]];
  assign discharge_and_load = regs[REG_DISCHARGE_AND_LOAD[4:0]];
  assign reset_and_fault_policy = regs[REG_RESET_AND_POLICY[4:0]];

  // ----------------------------------------
  // Event latches and interrupt pin
  // ----------------------------------------
  for (genvar g = 0; g < EVENT_REGS; g++) begin : g_event
    logic clear_now;
    logic [7:0] rise;
    assign clear_now = load_now && (load_addr == REG_LDO_LIMIT_EVENTS + 8'(g));
    assign rise = cond_s2[g] & ~cond_q[g];
    // A rise in the clearing cycle survives the clear.
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        event_flag[g] <= 8'h00;
      end else begin
        event_flag[g] <= (clear_now ? 8'h00 : event_flag[g]) | rise;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_n_pin <= 1'b1;
    end else begin
      irq_n_pin <= ~|((event_flag[0] & ~event_mask[0]) |
                      (event_flag[1] & ~event_mask[1]) |
                      (event_flag[2] & ~event_mask[2]));
    end
  end

endmodule

`default_nettype wire

// >>> rtl/pmr_pkg.sv
/*
  Shared constants of the power-rail register bank: register offsets,
  writable-bit layouts, reset values and serial link framing figures.
  Assumes nothing of its surroundings; imported whole by the bank.
*/
`default_nettype none

package pmr_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] REG_PRODUCT_CODE = 8'h00;
  localparam logic [7:0] REG_SILICON_REVISION = 8'h01;
  localparam logic [7:0] REG_BUCK_VOLTAGE = 8'h02;
  localparam logic [7:0] REG_BOOST_VOLTAGE = 8'h03;
  localparam logic [7:0] REG_LDO_ONE_VOLTAGE = 8'h04;
  localparam logic [7:0] REG_LDO_TWO_VOLTAGE = 8'h05;
  localparam logic [7:0] REG_LDO_THREE_VOLTAGE = 8'h06;
  localparam logic [7:0] REG_LDO_FOUR_VOLTAGE = 8'h07;
  localparam logic [7:0] REG_CURRENT_LIMIT = 8'h08;
  localparam logic [7:0] REG_RAIL_ENABLE = 8'h09;
  localparam logic [7:0] REG_BOOST_ENABLE_SET = 8'h0a;
  localparam logic [7:0] REG_BUCK_SLOT = 8'h0b;
  localparam logic [7:0] REG_LDO_ONE_TWO_SLOT = 8'h0c;
  localparam logic [7:0] REG_LDO_THREE_FOUR_SLOT = 8'h0d;
  localparam logic [7:0] REG_SEQUENCER_CONTROL = 8'h0e;
  localparam logic [7:0] REG_DISCHARGE_AND_LOAD = 8'h0f;
  localparam logic [7:0] REG_RESET_AND_POLICY = 8'h10;
  localparam logic [7:0] REG_LDO_LIMIT_EVENTS = 8'h11;
  localparam logic [7:0] REG_CONVERTER_EVENTS = 8'h12;
  localparam logic [7:0] REG_SUPPLY_EVENTS = 8'h13;
  localparam logic [7:0] REG_LDO_LIMIT_STATE = 8'h14;
  localparam logic [7:0] REG_CONVERTER_STATE = 8'h15;
  localparam logic [7:0] REG_SUPPLY_STATE = 8'h16;
  localparam logic [7:0] REG_LDO_LIMIT_MASK = 8'h17;
  localparam logic [7:0] REG_CONVERTER_MASK = 8'h18;
  localparam logic [7:0] REG_SUPPLY_MASK = 8'h19;
  localparam logic [7:0] REG_SUSPEND_STATE = 8'h1a;
  localparam logic [7:0] REG_LAST = 8'h1a;
  localparam logic [7:0] REG_POINTER_MAX = 8'hff;

  // ----------------------------------------
  // Writable bits and fixed read values
  // ----------------------------------------
  localparam logic [7:0] WMASK_FULL = 8'hff;
  localparam logic [7:0] WMASK_CURRENT_LIMIT = 8'h55;
  localparam logic [7:0] WMASK_RAIL_ENABLE = 8'hdf;
  localparam logic [7:0] WMASK_BUCK_SLOT = 8'h07;
  localparam logic [7:0] WMASK_PAIR_SLOT = 8'h3f;
  localparam logic [7:0] WMASK_RESET_AND_POLICY = 8'h79;
  localparam logic [7:0] WMASK_NONE = 8'h00;
  localparam logic [7:0] READ_ONE_RESET_AND_POLICY = 8'h02;
  localparam logic [7:0] FILL_BYTE = 8'h00;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RESET_CURRENT_LIMIT = 8'h55;
  localparam logic [7:0] RESET_OTHER = 8'h00;

  // ----------------------------------------
  // Link framing and array sizes
  // ----------------------------------------
  localparam logic [6:0] SLAVE_ADDRESS = 7'h35;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam int EVENT_REGS = 3;
  localparam int REG_COUNT = 27;

endpackage

`default_nettype wire

// >>> testbench/pmr_register_bank_asserts.sv
/*
  Concurrent checks on the ports of the power-rail register bank.
  Assumes one 100 MHz clock domain with a synchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none

module pmr_register_bank_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic irq_n_pin,
  input wire logic [7:0] ldo_limit_cond,
  input wire logic [7:0] converter_limit_cond,
  input wire logic [7:0] supply_thermal_cond,
  input wire logic [7:0] current_limit_select,
  input wire logic [7:0] rail_enable,
  input wire logic [7:0] buck_sequence_slot,
  input wire logic [7:0] ldo_one_two_sequence_slot,
  input wire logic [7:0] ldo_three_four_sequence_slot,
  input wire logic [7:0] reset_and_fault_policy
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  // Cycles since any live condition rose; saturates so a long quiet spell never wraps.
  logic [23:0] cond_q;
  logic [3:0] since_rise;
  wire logic [23:0] cond_now = {ldo_limit_cond, converter_limit_cond, supply_thermal_cond};
  wire logic any_rise = |(cond_now & ~cond_q);
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cond_q <= 24'h00_0000;
      since_rise <= 4'hf;
    end else begin
      cond_q <= cond_now;
      since_rise <= any_rise ? 4'h0 : ((since_rise == 4'hf) ? 4'hf : since_rise + 4'h1);
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence drive_held;
    !sda_oe_n [*6];
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_limit_odd_zero: assert property ((current_limit_select & 8'haa) == 8'h00)
    else $error("odd current limit bits set");
  a_enable_gap_zero: assert property (rail_enable[5] == 1'b0)
    else $error("rail enable bit five set");
  a_slot_upper_zero: assert property (buck_sequence_slot[7:3] == 5'h00 &&
    ldo_one_two_sequence_slot[7:6] == 2'h0 && ldo_three_four_sequence_slot[7:6] == 2'h0)
    else $error("sequence slot upper bits set");
  a_policy_fixed_bits: assert property (reset_and_fault_policy[7] == 1'b0 &&
    reset_and_fault_policy[2] == 1'b0)
    else $error("reset register fixed bits wrong");
  a_reset_defaults: assert property (disable iff (1'b0) !rst_n |=>
    reset_and_fault_policy[0] == 1'b0 && current_limit_select == 8'h55 && irq_n_pin)
    else $error("reset values wrong");
  a_drive_after_fall: assert property ($fell(sda_oe_n) |-> !scl_in && !$past(scl_in, 2))
    else $error("data drive began outside the low clock phase");
  a_drive_holds: assert property ($fell(sda_oe_n) |-> drive_held)
    else $error("data drive released too early");
  a_irq_has_cause: assert property ($fell(irq_n_pin) |-> since_rise <= 4'h8)
    else $error("interrupt asserted with no condition rise");
  a_drive_low_only: assert property (sda_out == 1'b0)
    else $error("data line driven high");
endmodule

bind pmr_register_bank pmr_register_bank_asserts chk_u (
  .clock(clock),
  .rst_n(rst_n),
  .scl_in(scl_in),
  .sda_out(sda_out),
  .sda_oe_n(sda_oe_n),
  .irq_n_pin(irq_n_pin),
  .ldo_limit_cond(ldo_limit_cond),
  .converter_limit_cond(converter_limit_cond),
  .supply_thermal_cond(supply_thermal_cond),
  .current_limit_select(current_limit_select),
  .rail_enable(rail_enable),
  .buck_sequence_slot(buck_sequence_slot),
  .ldo_one_two_sequence_slot(ldo_one_two_sequence_slot),
  .ldo_three_four_sequence_slot(ldo_three_four_sequence_slot),
  .reset_and_fault_policy(reset_and_fault_policy)
);

`default_nettype wire

// >>> testbench/pmr_host_model.sv
/*
  Serial link host: drives the clock line and releases or pulls the data line.
  Assumes the bench resolves the open-drain data wire with a pull-up.
*/
`timescale 1ns/1ns
`default_nettype none

module pmr_host_model (
  input wire logic clock,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_host
);
  // The clock line idles high between frames.
  initial begin
    scl = 1'b1;
    sda_host = 1'b1;
  end

  // One quarter of an 80 ns link clock period.
  task automatic q();
    repeat (2) @(posedge clock);
  endtask

  // Data changes only in the low phase, so no bit is mistaken for a frame edge.
  task automatic bit_io(input logic b, output logic seen);
    sda_host <= b;
    q();
    scl <= 1'b1;
    q();
    seen = sda_wire;
    q();
    scl <= 1'b0;
    q();
  endtask

  task automatic start_cond();
    sda_host <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_host <= 1'b0;
    q();
    scl <= 1'b0;
    q();
  endtask

  task automatic stop_cond();
    sda_host <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_host <= 1'b1;
    q();
    q();
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask

  task automatic get_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(!more, s);
  endtask
endmodule

`default_nettype wire

// >>> testbench/tb_top.sv
/*
  Self-checking bench for the power-rail register bank.
  Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import pmr_pkg::*;
  localparam logic [7:0] ID_PRODUCT = 8'h3c; // Arbitrary value.
  localparam logic [7:0] ID_REVISION = 8'hc3; // Arbitrary value.
  localparam logic [7:0] WM [15] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h55, 8'hdf,
    8'hff, 8'h07, 8'h3f, 8'h3f, 8'hff, 8'hff, 8'h79};
  logic clock, rst_n, sda_out, sda_oe_n, irq_n_pin;
  wire logic scl;
  wire logic sda_host;
  wire logic sda_wire = sda_host & (sda_oe_n | sda_out);
  logic [7:0] ldo_c, conv_c, sup_c;
  logic [6:0] susp_c;
  logic [14:0][7:0] ctl;
  logic [7:0] rq [$];
  int comparisons = 0;
  int n_mismatch = 0;

  pmr_host_model host_u (.clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_host(sda_host));

  pmr_register_bank #(.PRODUCT_CODE(ID_PRODUCT), .REVISION_CODE(ID_REVISION)) dut_u (
    .clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .irq_n_pin(irq_n_pin), .ldo_limit_cond(ldo_c),
    .converter_limit_cond(conv_c), .supply_thermal_cond(sup_c), .suspend_cond(susp_c),
    .buck_voltage(ctl[0]), .boost_voltage(ctl[1]), .ldo_one_voltage(ctl[2]),
    .ldo_two_voltage(ctl[3]), .ldo_three_voltage(ctl[4]), .ldo_four_voltage(ctl[5]),
    .current_limit_select(ctl[6]), .rail_enable(ctl[7]), .boost_enable_set(ctl[8]),
    .buck_sequence_slot(ctl[9]), .ldo_one_two_sequence_slot(ctl[10]),
    .ldo_three_four_sequence_slot(ctl[11]), .sequencer_control(ctl[12]),
    .discharge_and_load(ctl[13]), .reset_and_fault_policy(ctl[14]));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d [$]);
    logic a;
    host_u.start_cond();
    host_u.send_byte({7'h35, 1'b0}, a);
    check("write address ack", {7'h00, a}, 8'h01);
    host_u.send_byte(ptr, a);
    foreach (d[i]) begin
      host_u.send_byte(d[i], a);
    end
    host_u.stop_cond();
  endtask

  task automatic rd(input logic [7:0] ptr, input int n);
    logic a;
    logic [7:0] b;
    rq = {};
    host_u.start_cond();
    host_u.send_byte({7'h35, 1'b0}, a);
    host_u.send_byte(ptr, a);
    host_u.start_cond();
    host_u.send_byte({7'h35, 1'b1}, a);
    check("read address ack", {7'h00, a}, 8'h01);
    for (int i = 0; i < n; i++) begin
      host_u.get_byte(i < n - 1, b);
      rq.push_back(b);
    end
    host_u.stop_cond();
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 15; i++) begin
      check("reset value", ctl[i], (i == 6) ? 8'h55 : 8'h00);
    end
    check("pins idle", {6'h00, irq_n_pin, sda_oe_n}, 8'h03);
  endtask

  task automatic t_regs();
    logic [7:0] p;
    logic [7:0] d [$];
    for (int k = 0; k < 2; k++) begin
      p = (k == 0) ? 8'hff : 8'h00;
      d = {};
      for (int i = 0; i < 15; i++) begin
        d.push_back(p);
      end
      wr(8'h02, d);
      rd(8'h02, 15);
      for (int i = 0; i < 15; i++) begin
        check("register read back", rq[i], (p & WM[i]) | ((i == 14) ? 8'h02 : 8'h00));
        if (i < 14) check("register port", ctl[i], p & WM[i]);
      end
    end
  endtask

  task automatic t_ids();
    wr(8'h00, '{8'h11, 8'h22});
    rd(8'h00, 2);
    check("product code", rq[0], ID_PRODUCT);
    check("revision code", rq[1], ID_REVISION);
  endtask

  task automatic t_tail();
    susp_c <= 7'h7f;
    rd(8'h19, 3);
    check("mask default", rq[0], 8'h00);
    check("suspend flags", rq[1], 8'h7f);
    check("past last", rq[2], 8'h00);
  endtask

  task automatic t_events();
    int k;
    ldo_c <= 8'h81;
    for (k = 0; k < 50 && irq_n_pin !== 1'b0; k++) @(posedge clock);
    if (k == 50) begin
      n_mismatch++;
      close_out();
    end
    rd(8'h11, 1);
    check("event latched", rq[0], 8'h81);
    check("irq after clear", {7'h00, irq_n_pin}, 8'h01);
    rd(8'h14, 1);
    check("live state", rq[0], 8'h81);
    wr(8'h19, '{8'hff});
    sup_c <= 8'h02;
    repeat (20) @(posedge clock);
    check("masked irq", {7'h00, irq_n_pin}, 8'h01);
    rd(8'h13, 2);
    check("masked event", rq[0], 8'h02);
    check("status after event", rq[1], 8'h81);
    conv_c <= 8'h10;
    repeat (20) @(posedge clock);
    check("unmasked irq", {7'h00, irq_n_pin}, 8'h00);
    rd(8'h12, 1);
    check("converter event", rq[0], 8'h10);
    check("irq released", {7'h00, irq_n_pin}, 8'h01);
  endtask

  task automatic t_bad_address();
    logic a;
    host_u.start_cond();
    host_u.send_byte({7'h34, 1'b0}, a);
    host_u.stop_cond();
    check("foreign address ack", {7'h00, a}, 8'h00);
  endtask

  // ----------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    repeat (100000) @(posedge clock);
    n_mismatch++;
    close_out();
  end

  initial begin
    rst_n = 1'b0;
    ldo_c = 8'h00;
    conv_c = 8'h00;
    sup_c = 8'h00;
    susp_c = 7'h00;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_reset();
    t_regs();
    t_ids();
    t_tail();
    t_events();
    t_bad_address();
    close_out();
  end
endmodule

`default_nettype wire
